// ==== src/lhp_consts.svh ====
`ifndef LHP_CONSTS_SVH
`define LHP_CONSTS_SVH

`define LHP_OFF_MODE 5'h00
`define LHP_OFF_LPW 5'h04
`define LHP_OFF_CSW 5'h06
`define LHP_OFF_ALT 5'h0e
`define LHP_OFF_DATA 5'h10
`define LHP_OFF_MEM_INDEX_LOW 5'h12
`define LHP_OFF_MEM_INDEX_HIGH 5'h14
`define LHP_ALT_RST 8'h00
`define LHP_LPW_RST 8'h01
`define LHP_CSW_RST 8'h00
`define LHP_DIV_RST 3'h0
`define LHP_DIV_LSB 3
`define LHP_DIV_MSB 5
`define LHP_IDX_MAX 14'h257f
`define LHP_MEM_BYTES 9600
`define LHP_LINE_BYTES 8'h28
`define LHP_FRAME_LINES 8'hf0
`define LHP_STEAL_MAX 2'h3

`endif

// ==== src/lhp_pkg.sv ====
package lhp_pkg;
    typedef enum logic [1:0] {
        LHP_IDLE = 2'b00,
        LHP_WAIT = 2'b01,
        LHP_DONE = 2'b10,
        LHP_HOLD = 2'b11
    } lhp_mst_t;
endpackage

// ==== src/lhp_sync.sv ====
`timescale 1ns/1ns
module lhp_sync #(
    parameter int W = 1
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s1_q <= '1;
            q <= '1;
        end
        else
        begin
            s1_q <= d;
            q <= s1_q;
        end
    end
endmodule

// ==== src/lhp_top.sv ====
`timescale 1ns/1ns
`include "lhp_consts.svh"
// How it works
// - Alternation toggles each frame at zero, else every N line pulses.
// - Data window gives byte read and write of memory at index.
// - Each completed data window access bumps the memory index by one.
// - Data window reads return memory at index, taken as the access opens.
// - Register access only while select and write or read strobe low.
// - Access starts at last qualifier low, ends at first high.
// - Memory access outside steal window is select overlapping strobe.
// - Wait released in step with a host bus clock edge.
// - Read data valid no later than wait release.
// - Division setting applied on an oscillator rising edge.
// - LCD outputs generated synchronously to the divided clock.
// - Memory access in steal window finishes in one or two divided clock cycles.
module lhp_top
    import lhp_pkg::*;
#(
    parameter int IDX_W = 14,
    parameter int DEPTH = `LHP_MEM_BYTES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [4:0] ADDR,
    input wire logic [13:0] MEM_ADDR,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE_N,
    input wire logic REG_SELECT_N,
    input wire logic MEM_SELECT_N,
    input wire logic LOW_WRITE_STROBE_N,
    input wire logic HIGH_WRITE_STROBE_N,
    input wire logic READ_N,
    input wire logic HOST_BUS_CLOCK,
    input wire logic OSCILLATOR_INPUT,
    output logic WAIT_N,
    output logic SHIFT_CLOCK,
    output logic LINE_PULSE,
    output logic FIRST_LINE_MARKER,
    output logic ALTERNATION
);
    logic [6:0] raw;
    logic [6:0] syn;
    logic rsel_n, msel_n, lwr_n, hwr_n, rd_n, bclk, osc;
    logic [7:0] mem [DEPTH];
    logic [7:0] alt_q, lpw_q, csw_q;
    logic [2:0] div_q;
    logic [IDX_W-1:0] idx_q;
    logic [7:0] win_q;
    logic reg_act, reg_act_q, reg_wr, reg_end, lwr_seen_q;
    logic mem_act;
    lhp_mst_t mst_q;
    logic [1:0] steal_q, need_q;
    logic bclk_q, osc_q, osc_rise, bclk_rise;
    logic [3:0] dcnt_q;
    logic tick;
    logic phase_q;
    logic [7:0] col_q, line_q, lpc_q, altc_q;
    logic [8:0] flm_q;
    logic steal_win;
    logic [7:0] rdata_q;
    logic oe_q;
    logic mem_done;

    assign raw = {OSCILLATOR_INPUT, HOST_BUS_CLOCK, READ_N,
        HIGH_WRITE_STROBE_N, LOW_WRITE_STROBE_N, MEM_SELECT_N,
        REG_SELECT_N};

    lhp_sync #(.W(7)) u_sync (
        .CLK(CLK),
        .RST(RST),
        .d(raw),
        .q(syn)
    );

    assign {osc, bclk, rd_n, hwr_n, lwr_n, msel_n, rsel_n} = syn;

    // Qualified overlaps
    assign reg_act = !rsel_n && (!lwr_n || !rd_n);
    assign mem_act = !msel_n && (!lwr_n || !hwr_n || !rd_n);
    // Write commits once the overlap ends, if the write strobe was seen
    assign reg_wr = reg_act_q && !reg_act && lwr_seen_q;
    assign reg_end = reg_act_q && !reg_act;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            reg_act_q <= 1'b0;
            lwr_seen_q <= 1'b0;
        end
        else
        begin
            reg_act_q <= reg_act;
            if (reg_act && !lwr_n)
                lwr_seen_q <= 1'b1;
            else if (!reg_act)
                lwr_seen_q <= 1'b0;
        end
    end

    // Edge detectors on synchronised clocks
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            bclk_q <= 1'b1;
            osc_q <= 1'b1;
        end
        else
        begin
            bclk_q <= bclk;
            osc_q <= osc;
        end
    end
    assign osc_rise = osc && !osc_q;
    assign bclk_rise = bclk && !bclk_q;

    // Address and data taken as the overlap opens; pins may move after
    logic [7:0] wdata_q;
    logic [4:0] waddr_q;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wdata_q <= 8'h00;
            waddr_q <= 5'h00;
        end
        else if (reg_act && !reg_act_q)
        begin
            wdata_q <= DATA_IN;
            waddr_q <= ADDR;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            alt_q <= `LHP_ALT_RST;
            lpw_q <= `LHP_LPW_RST;
            csw_q <= `LHP_CSW_RST;
        end
        else if (reg_wr)
        begin
            unique case (waddr_q)
                `LHP_OFF_ALT: alt_q <= wdata_q;
                `LHP_OFF_LPW: lpw_q <= wdata_q;
                `LHP_OFF_CSW: csw_q <= wdata_q;
                default: ;
            endcase
        end
    end

    // Division setting taken on oscillator rising edge
    logic [2:0] div_pend_q;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            div_pend_q <= `LHP_DIV_RST;
            div_q <= `LHP_DIV_RST;
        end
        else
        begin
            if (reg_wr && waddr_q == `LHP_OFF_MODE)
                div_pend_q <= wdata_q[`LHP_DIV_MSB:`LHP_DIV_LSB];
            if (osc_rise)
                div_q <= div_pend_q;
        end
    end

    // Memory index and data window
    logic win_acc;
    assign win_acc = reg_end && waddr_q == `LHP_OFF_DATA;
    always_ff @(posedge CLK)
    begin
        if (RST)
            idx_q <= '0;
        else if (reg_wr && waddr_q == `LHP_OFF_MEM_INDEX_LOW)
            idx_q <= {idx_q[IDX_W-1:8], wdata_q};
        else if (reg_wr && waddr_q == `LHP_OFF_MEM_INDEX_HIGH)
            idx_q <= {wdata_q[IDX_W-9:0], idx_q[7:0]};
        else if (win_acc)
            idx_q <= (idx_q == `LHP_IDX_MAX) ? '0 : idx_q + 1'b1;
    end

    // Memory port: window access or direct host access
    always_ff @(posedge CLK)
    begin
        if (RST)
            win_q <= 8'h00;
        else if (reg_act && !reg_act_q && ADDR == `LHP_OFF_DATA)
            win_q <= mem[idx_q];
    end

    always_ff @(posedge CLK)
    begin
        if (reg_wr && waddr_q == `LHP_OFF_DATA)
            mem[idx_q] <= wdata_q;
        else if (mst_q == LHP_WAIT && mem_done && !lwr_n)
            mem[MEM_ADDR] <= DATA_IN;
    end

    // Divided clock, shift clock, line and frame timing
    assign tick = osc_rise && dcnt_q == ((4'h1 << div_q) - 4'h1);
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            dcnt_q <= 4'h0;
            phase_q <= 1'b0;
        end
        else if (osc_rise)
        begin
            dcnt_q <= tick ? 4'h0 : dcnt_q + 4'h1;
            if (tick)
                phase_q <= !phase_q;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            col_q <= 8'h00;
            line_q <= 8'h00;
            flm_q <= 9'h000;
            LINE_PULSE <= 1'b0;
            SHIFT_CLOCK <= 1'b0;
        end
        else if (tick)
        begin
            SHIFT_CLOCK <= !SHIFT_CLOCK;
            col_q <= (col_q == `LHP_LINE_BYTES) ? 8'h00 : col_q + 8'h01;
            LINE_PULSE <= col_q == `LHP_LINE_BYTES;
            if (col_q == `LHP_LINE_BYTES)
                line_q <= (line_q == `LHP_FRAME_LINES - 8'h01) ? 8'h00
                    : line_q + 8'h01;
            if (col_q == `LHP_LINE_BYTES && line_q == 8'h00)
                flm_q <= {lpw_q, 1'b0};
            else if (flm_q != 9'h000)
                flm_q <= flm_q - 9'h001;
        end
    end
    assign FIRST_LINE_MARKER = flm_q != 9'h000;

    logic line_ev, frame_ev;
    assign line_ev = tick && col_q == `LHP_LINE_BYTES;
    assign frame_ev = line_ev && line_q == `LHP_FRAME_LINES - 8'h01;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            altc_q <= 8'h00;
            ALTERNATION <= 1'b0;
        end
        else if (alt_q == 8'h00)
        begin
            altc_q <= 8'h00;
            if (frame_ev)
                ALTERNATION <= !ALTERNATION;
        end
        else if (line_ev)
        begin
            if (altc_q + 8'h01 >= alt_q)
            begin
                altc_q <= 8'h00;
                ALTERNATION <= !ALTERNATION;
            end
            else
                altc_q <= altc_q + 8'h01;
        end
    end

    // Steal window: first csw characters of each line
    assign steal_win = col_q < csw_q;

    // Memory access wait machine
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            mst_q <= LHP_IDLE;
            steal_q <= 2'h0;
            need_q <= 2'h0;
            rdata_q <= 8'h00;
        end
        else
        begin
            unique case (mst_q)
                LHP_IDLE:
                    if (mem_act)
                    begin
                        mst_q <= LHP_WAIT;
                        steal_q <= 2'h0;
                        need_q <= steal_win ? {1'b0, phase_q} + 2'h1 : 2'h0;
                    end
                LHP_WAIT:
                    if (mem_done)
                    begin
                        rdata_q <= mem[MEM_ADDR];
                        mst_q <= LHP_DONE;
                    end
                    else if (tick)
                        steal_q <= steal_q + 2'h1;
                LHP_DONE:
                    if (bclk_rise)
                        mst_q <= LHP_HOLD;
                LHP_HOLD:
                    if (!mem_act)
                        mst_q <= LHP_IDLE;
            endcase
        end
    end
    assign mem_done = steal_q >= need_q || need_q > `LHP_STEAL_MAX;
    assign WAIT_N = !(mst_q == LHP_WAIT || mst_q == LHP_DONE);

    // Read data drive
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            DATA_OUT <= 8'h00;
            oe_q <= 1'b0;
        end
        else
        begin
            oe_q <= (reg_act && !rd_n) || (mem_act && !rd_n);
            // Data settles with the done step, before wait is released
            if (mst_q == LHP_WAIT && mem_done)
                DATA_OUT <= mem[MEM_ADDR];
            else if (mem_act && mst_q != LHP_IDLE)
                DATA_OUT <= rdata_q;
            else if (reg_act && waddr_q == `LHP_OFF_DATA)
                DATA_OUT <= win_q;
            else if (reg_act && waddr_q == `LHP_OFF_MEM_INDEX_LOW)
                DATA_OUT <= idx_q[7:0];
            else if (reg_act && waddr_q == `LHP_OFF_MEM_INDEX_HIGH)
                DATA_OUT <= {{(16 - IDX_W){1'b0}}, idx_q[IDX_W-1:8]};
            else
                DATA_OUT <= 8'h00;
        end
    end
    assign DATA_OE_N = !oe_q;
endmodule

// ==== bench/lhp_top_properties.sv ====
`timescale 1ns/1ns
module lhp_checker (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] DATA_OUT,
    input wire logic DATA_OE_N,
    input wire logic MEM_SELECT_N,
    input wire logic READ_N,
    input wire logic LOW_WRITE_STROBE_N,
    input wire logic HOST_BUS_CLOCK,
    input wire logic OSCILLATOR_INPUT,
    input wire logic WAIT_N,
    input wire logic LINE_PULSE,
    input wire logic ALTERNATION
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_rd_release;
        $rose(WAIT_N) && !READ_N;
    endsequence
    sequence s_mem_idle;
        MEM_SELECT_N [*4];
    endsequence
    a_wait_cause: assert property ($fell(WAIT_N) |->
        $past(!MEM_SELECT_N) && $past(!READ_N || !LOW_WRITE_STROBE_N))
        else $error("wait asserted without memory access");
    a_wait_bus_clock: assert property ($rose(WAIT_N) |->
        HOST_BUS_CLOCK && $past(HOST_BUS_CLOCK, 2))
        else $error("wait released off a host clock rise");
    a_rd_data_ready: assert property (s_rd_release |->
        !DATA_OE_N && $stable(DATA_OUT))
        else $error("read data not settled at wait release");
    a_idle_no_wait: assert property (s_mem_idle |-> WAIT_N)
        else $error("wait low while memory not selected");
    a_drive_on_read: assert property (!DATA_OE_N |->
        $past(!READ_N, 2) || $past(!READ_N, 3) || $past(!READ_N, 4))
        else $error("data driven without a read");
    a_no_read_off: assert property (READ_N [*6] |-> DATA_OE_N)
        else $error("data driven long after read ended");
    a_line_osc_sync: assert property ($changed(LINE_PULSE) |->
        $past(OSCILLATOR_INPUT, 3))
        else $error("line pulse moved off oscillator rise");
    a_alt_osc_sync: assert property ($changed(ALTERNATION) |->
        $past(OSCILLATOR_INPUT, 3))
        else $error("alternation moved off oscillator rise");
    a_reset_outs: assert property (disable iff (1'b0)
        RST |=> WAIT_N && DATA_OE_N)
        else $error("outputs not idle after reset");
endmodule
bind lhp_top lhp_checker u_lhp_checker (.*);

// ==== bench/lhp_host.sv ====
`timescale 1ns/1ns
module lhp_host (
    input wire logic CLK,
    input wire logic [7:0] DATA_OUT,
    input wire logic WAIT_N,
    output logic [4:0] ADDR,
    output logic [13:0] MEM_ADDR,
    output logic [7:0] DATA_IN,
    output logic REG_SELECT_N,
    output logic MEM_SELECT_N,
    output logic LOW_WRITE_STROBE_N,
    output logic HIGH_WRITE_STROBE_N,
    output logic READ_N,
    output logic HOST_BUS_CLOCK,
    output logic OSCILLATOR_INPUT
);
    initial
    begin
        {REG_SELECT_N, MEM_SELECT_N, LOW_WRITE_STROBE_N} = 3'h7;
        {HIGH_WRITE_STROBE_N, READ_N, HOST_BUS_CLOCK} = 3'h6;
        {ADDR, MEM_ADDR, DATA_IN} = 27'h0;
        OSCILLATOR_INPUT = 1'b0;
    end
    // Free running host bus clock
    always #48 HOST_BUS_CLOCK = ~HOST_BUS_CLOCK;
    // Slow enough to run undivided
    always #64 OSCILLATOR_INPUT = ~OSCILLATOR_INPUT;
    // Op 1 writes, 2 reads, 0 selects without a strobe
    task automatic acc(input logic io, input logic [1:0] op,
        input logic [13:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge CLK);
        {ADDR, MEM_ADDR, DATA_IN} = {a[4:0], a, d};
        if (io)
            REG_SELECT_N = 1'b0;
        else
            MEM_SELECT_N = 1'b0;
        @(negedge CLK);
        // Strobe falls last and opens the access
        LOW_WRITE_STROBE_N = !op[0];
        READ_N = !op[1];
        if (io)
            repeat (6) @(posedge CLK);
        else
        begin
            repeat (8) if (WAIT_N) @(posedge CLK);
            repeat (400) if (!WAIT_N) @(posedge CLK);
        end
        @(negedge CLK);
        q = DATA_OUT;
        // All qualifiers return high before the next access
        {REG_SELECT_N, MEM_SELECT_N, LOW_WRITE_STROBE_N, READ_N} = 4'hf;
        {ADDR, MEM_ADDR, DATA_IN} = ~{ADDR, MEM_ADDR, DATA_IN};
        repeat (6) @(negedge CLK);
    endtask
endmodule

// ==== bench/lhp_top_tb.sv ====
`timescale 1ns/1ns
`include "lhp_consts.svh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module lhp_top_tb;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [4:0] ADDR;
    logic [13:0] MEM_ADDR;
    logic [7:0] DATA_IN, DATA_OUT;
    logic DATA_OE_N, REG_SELECT_N, MEM_SELECT_N, READ_N, WAIT_N;
    logic LOW_WRITE_STROBE_N, HIGH_WRITE_STROBE_N;
    logic HOST_BUS_CLOCK, OSCILLATOR_INPUT, SHIFT_CLOCK;
    logic LINE_PULSE, FIRST_LINE_MARKER, ALTERNATION;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [13:0] ad [3] = '{14'h257e, 14'h257f, 14'h0000};
    always #4 CLK = ~CLK;
    lhp_top u_lhp_top (.*);
    lhp_host u_lhp_host (.*);
    task automatic rg(input logic [1:0] op, input logic [4:0] a,
        input logic [7:0] d, output logic [7:0] q);
        u_lhp_host.acc(1'b1, op, {9'h0, a}, d, q);
    endtask
    task automatic t_refuse;
        logic [7:0] q;
        rg(2'd1, `LHP_OFF_MEM_INDEX_LOW, 8'h10, q);
        rg(2'd0, `LHP_OFF_MEM_INDEX_LOW, 8'h33, q);
        rg(2'd2, `LHP_OFF_MEM_INDEX_LOW, 8'h00, q);
        `CHK("idx_no_strobe", 8'h10, q)
        rg(2'd2, 5'h1e, 8'h00, q);
        `CHK("unmapped", 8'h00, q)
    endtask
    task automatic t_window;
        logic [7:0] q;
        rg(2'd1, `LHP_OFF_MEM_INDEX_HIGH, 8'h25, q);
        rg(2'd1, `LHP_OFF_MEM_INDEX_LOW, 8'h7e, q);
        for (int i = 0; i < 3; i++)
            rg(2'd1, `LHP_OFF_DATA, 8'ha0 + 8'(i), q);
        rg(2'd2, `LHP_OFF_MEM_INDEX_LOW, 8'h00, q);
        `CHK("idx_wrap", 8'h01, q)
        for (int i = 0; i < 3; i++)
        begin
            u_lhp_host.acc(1'b0, 2'd2, ad[i], 8'h00, q);
            `CHK("mem_rd", 8'ha0 + 8'(i), q)
        end
        rg(2'd1, `LHP_OFF_MEM_INDEX_HIGH, 8'h25, q);
        rg(2'd1, `LHP_OFF_MEM_INDEX_LOW, 8'h7e, q);
        for (int i = 0; i < 3; i++)
        begin
            rg(2'd2, `LHP_OFF_DATA, 8'h00, q);
            `CHK("win_rd", 8'ha0 + 8'(i), q)
        end
    endtask
    task automatic t_mem;
        logic [7:0] q;
        u_lhp_host.acc(1'b0, 2'd1, 14'h0100, 8'hc3, q);
        rg(2'd1, `LHP_OFF_MEM_INDEX_HIGH, 8'h01, q);
        rg(2'd1, `LHP_OFF_MEM_INDEX_LOW, 8'h00, q);
        rg(2'd2, `LHP_OFF_DATA, 8'h00, q);
        `CHK("mem_wr", 8'hc3, q)
        rg(2'd2, `LHP_OFF_MEM_INDEX_LOW, 8'h00, q);
        `CHK("idx_after_rd", 8'h01, q)
    endtask
    task automatic t_alt;
        logic [7:0] q;
        logic a;
        logic l;
        int t;
        int n;
        for (int k = 1; k < 3; k++)
        begin
            rg(2'd1, `LHP_OFF_ALT, k[7:0], q);
            {t, n, a, l} = {32'h0, 32'h0, ALTERNATION, LINE_PULSE};
            repeat (40000)
            begin
                @(negedge CLK);
                if (t == 2 && LINE_PULSE && !l)
                    n++;
                l = LINE_PULSE;
                if (ALTERNATION !== a)
                    t++;
                a = ALTERNATION;
                if (t == 3)
                    break;
            end
            `CHK("alt_lines", k, n)
        end
    endtask
    task automatic summarize;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #600000;
        n_mismatch++;
        summarize();
    end
    initial
    begin
        repeat (12) @(posedge CLK);
        @(negedge CLK);
        RST = 1'b0;
        t_refuse();
        t_window();
        t_mem();
        t_alt();
        summarize();
    end
endmodule
